// file: src/aics_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module aics_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 4
) (
	// Clock and control
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// Streams
	aics_stream_if.snk in_s,
	aics_stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_s.ready = (count != AW'(0) + (AW+1)'(DEPTH)) && ce_i;
	assign out_s.valid = count != '0;
	assign out_s.data = mem[rptr];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready && ce_i;

	always_ff @(posedge clk_i)
	begin
		if (ce_i && push)
		begin
			mem[wptr] <= in_s.data;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end
		else if (ce_i)
		begin
			if (push)
				wptr <= AW'(wptr + 1'b1);
			if (pop)
				rptr <= AW'(rptr + 1'b1);
			count <= (AW+1)'(count + push - pop);
		end
	end
endmodule

// file: src/aics_pkg.sv
// Package of constants and types for the analog input conversion sequencer
// Notes on behaviour
// - Sector match flag high from first word to digit time six of second.
// - Drum write enable flag is high throughout the whole second word.
// - Relay gate guard allows at most one closed relay of the set.
// - Relay select counter: five flip flops, each state one relay set.
// - Revolution counter gives a settling delay before sampling inputs.
// - Digit counter: five flip flops, digit times in plain binary.
// - Second word finishes conversion and shifts result serially to drum.
// - Sector counter flip flops decide when conversions take place.
// - Track eight head driven from serial result, gated by control.
// - Track holds 128 sectors, each a 17-bit word plus sign.
// - Extended word driver gives the lengthened conversion word time.
// - Sector compare driver compares current sector with target sector.
// - Sector track reader pulses resynchronise the digit counters.
package aics_pkg;
	localparam int AICS_SECTORS = 128;
	localparam int AICS_SECTOR_W = 7;
	localparam int AICS_WORD_BITS = 18;
	localparam int AICS_DIGIT_W = 5;
	localparam logic [4:0] AICS_DIGIT_LAST = 5'h11;
	localparam logic [4:0] AICS_DIGIT_SIX = 5'h06;
	localparam int AICS_RELAY_W = 5;
	localparam int AICS_REV_W = 4;
	localparam logic [3:0] AICS_SETTLE_REVS = 4'h3;
	localparam logic [4:0] AICS_DIGIT_RST = 5'h00;
	localparam int AICS_FIFO_DEPTH = 4;
	typedef enum logic [2:0] {
		AICS_IDLE,
		AICS_SETTLE,
		AICS_WAIT_SECTOR,
		AICS_FIRST_WORD,
		AICS_SECOND_WORD
	} aics_state_e;
endpackage

// file: src/aics_sequencer.sv
// Analog input conversion sequencer: relay, settle, sector and drum write
`timescale 1ns/100ps
module aics_sequencer
	import aics_pkg::*;
(
	// Clock and control
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// Drum timing
	input wire logic digit_strobe_i,
	input wire logic sector_track_reader_i,
	input wire logic revolution_mark_i,
	// Request
	input wire logic start_i,
	input wire logic [aics_pkg::AICS_RELAY_W-1:0] relay_set_i,
	input wire logic [aics_pkg::AICS_SECTOR_W-1:0] target_sector_i,
	output logic busy_o,
	// Converter
	input wire logic convert_bit_i,
	output logic [aics_pkg::AICS_RELAY_W-1:0] relay_select_counter_o,
	output logic relay_gate_guard_o,
	output logic sector_match_flag_o,
	output logic drum_write_enable_flag_o,
	output logic extended_word_driver_o,
	output logic sector_compare_driver_o,
	output logic [aics_pkg::AICS_DIGIT_W-1:0] conversion_digit_counter_o,
	output logic [aics_pkg::AICS_SECTOR_W-1:0] sector_count_o,
	// Track eight write head
	output logic converted_word_write_circuit_o,
	// Converted word stream
	output logic word_valid_o,
	input wire logic word_ready_i,
	output logic [aics_pkg::AICS_WORD_BITS-1:0] word_data_o
);
	import aics_pkg::*;

	aics_state_e state;
	logic [AICS_RELAY_W-1:0] relay_select_counter;
	logic [AICS_REV_W-1:0] settle_revolution_counter;
	logic [AICS_DIGIT_W-1:0] conversion_digit_counter;
	logic [AICS_SECTOR_W-1:0] sector_count;
	logic [AICS_SECTOR_W-1:0] target;
	logic [AICS_WORD_BITS-1:0] shift_word;
	logic sector_match_flag;
	logic drum_write_enable_flag;
	logic relay_gate_guard;
	logic write_bit;
	logic word_end;
	logic sector_hit;
	logic fifo_ready;

	aics_stream_if #(.WIDTH(AICS_WORD_BITS)) fill_s ();
	aics_stream_if #(.WIDTH(AICS_WORD_BITS)) drain_s ();

	// Word ends on last digit of an 18-digit sector
	assign word_end = digit_strobe_i
		&& conversion_digit_counter == AICS_DIGIT_LAST;
	assign sector_hit = sector_count == target;

	// Digit counter, binary, realigned by sector track pulses
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			conversion_digit_counter <= AICS_DIGIT_RST;
		else if (ce_i)
		begin
			if (sector_track_reader_i)
				conversion_digit_counter <= AICS_DIGIT_RST;
			else if (word_end)
				conversion_digit_counter <= AICS_DIGIT_RST;
			else if (digit_strobe_i)
				conversion_digit_counter <= AICS_DIGIT_W'(
					conversion_digit_counter + 1'b1);
		end
	end

	// Sector counter wraps at 128 per revolution
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			sector_count <= '0;
		else if (ce_i)
		begin
			if (revolution_mark_i)
				sector_count <= '0;
			else if (word_end)
				sector_count <= AICS_SECTOR_W'(sector_count + 1'b1);
		end
	end

	// Sequence control
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state <= AICS_IDLE;
			relay_select_counter <= '0;
			settle_revolution_counter <= '0;
			target <= '0;
			relay_gate_guard <= 1'b0;
		end
		else if (ce_i)
		begin
			case (state)
			AICS_IDLE:
			begin
				if (start_i)
				begin
					// Guard drops first, so no second relay closes
					relay_gate_guard <= 1'b0;
					relay_select_counter <= relay_set_i;
					target <= target_sector_i;
					settle_revolution_counter <= '0;
					state <= AICS_SETTLE;
				end
			end
			AICS_SETTLE:
			begin
				relay_gate_guard <= 1'b1;
				if (revolution_mark_i)
				begin
					settle_revolution_counter <= AICS_REV_W'(
						settle_revolution_counter + 1'b1);
					if (settle_revolution_counter + 1'b1 >= AICS_SETTLE_REVS)
						state <= AICS_WAIT_SECTOR;
				end
			end
			AICS_WAIT_SECTOR:
			begin
				if (word_end && sector_hit)
					state <= AICS_FIRST_WORD;
			end
			AICS_FIRST_WORD:
			begin
				if (word_end)
					state <= AICS_SECOND_WORD;
			end
			AICS_SECOND_WORD:
			begin
				// Hold until buffer accepts, so no word is dropped
				if (word_end && fifo_ready)
				begin
					state <= AICS_IDLE;
					relay_gate_guard <= 1'b0;
				end
			end
			default:
				state <= AICS_IDLE;
			endcase
		end
	end

	// Flags follow the sequence
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			sector_match_flag <= 1'b0;
			drum_write_enable_flag <= 1'b0;
		end
		else if (ce_i)
		begin
			if (state == AICS_WAIT_SECTOR && word_end && sector_hit)
				sector_match_flag <= 1'b1;
			else if (state == AICS_SECOND_WORD && digit_strobe_i
				&& conversion_digit_counter == AICS_DIGIT_SIX)
				sector_match_flag <= 1'b0;
			if (state == AICS_FIRST_WORD && word_end)
				drum_write_enable_flag <= 1'b1;
			else if (state == AICS_SECOND_WORD && word_end && fifo_ready)
				drum_write_enable_flag <= 1'b0;
		end
	end

	// Serial result shift and track eight write bit
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			shift_word <= '0;
			write_bit <= 1'b0;
		end
		else if (ce_i && digit_strobe_i)
		begin
			if (drum_write_enable_flag)
			begin
				shift_word <= {convert_bit_i,
					shift_word[AICS_WORD_BITS-1:1]};
				write_bit <= convert_bit_i;
			end
			else
				write_bit <= 1'b0;
		end
	end

	assign fill_s.valid = state == AICS_SECOND_WORD && word_end;
	assign fill_s.data = {convert_bit_i, shift_word[AICS_WORD_BITS-1:1]};
	assign fifo_ready = fill_s.ready;
	assign drain_s.ready = word_ready_i;

	aics_fifo #(.WIDTH(AICS_WORD_BITS), .DEPTH(AICS_FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.in_s(fill_s),
		.out_s(drain_s)
	);

	assign word_valid_o = drain_s.valid;
	assign word_data_o = drain_s.data;
	assign busy_o = state != AICS_IDLE;
	assign relay_select_counter_o = relay_select_counter;
	assign relay_gate_guard_o = relay_gate_guard;
	assign sector_match_flag_o = sector_match_flag;
	assign drum_write_enable_flag_o = drum_write_enable_flag;
	assign extended_word_driver_o = sector_match_flag
		| drum_write_enable_flag;
	assign sector_compare_driver_o = sector_hit && state == AICS_WAIT_SECTOR;
	assign conversion_digit_counter_o = conversion_digit_counter;
	assign sector_count_o = sector_count;
	// Loads only under the write flag; a digit late, so bit 17 is not lost
	assign converted_word_write_circuit_o = write_bit;
endmodule

// file: src/aics_stream_if.sv
// Valid/ready word stream between sequencer and its buffer
`timescale 1ns/100ps
interface aics_stream_if #(parameter int WIDTH = 18);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// file: verification/aics_drum_model.sv
// Drum timing and converter bit model for the sequencer bench
`timescale 1ns/100ps
module aics_drum_model (
	// Clock, reset and converter value
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [17:0] pat_i,
	// Drum timing and serial bit
	output logic ds_o,
	output logic rd_o,
	output logic rm_o,
	output logic cb_o
);
	logic [4:0] dig;
	logic [6:0] sec;
	// Inverted off the strobe so a mistimed sample shows
	assign cb_o = ds_o ? pat_i[dig] : ~pat_i[dig];
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			ds_o <= 1'b0;
			rd_o <= 1'b0;
			rm_o <= 1'b0;
			dig <= 5'h00;
			sec <= 7'h00;
		end
		else if (ds_o)
		begin
			ds_o <= 1'b0;
			rd_o <= dig == 5'h11;
			rm_o <= dig == 5'h11 && sec == 7'h7F;
			dig <= dig == 5'h11 ? 5'h00 : dig + 5'h01;
			sec <= dig == 5'h11 ? sec + 7'h01 : sec;
		end
		else
		begin
			// Pulses sit in the gap so they never meet a strobe
			ds_o <= 1'b1;
			rd_o <= 1'b0;
			rm_o <= 1'b0;
		end
	end
endmodule

// file: verification/aics_properties.sv
// Port checks for the conversion sequencer
`timescale 1ns/100ps
module aics_properties
	import aics_pkg::*;
(
	// Clock, control, timing and converter bit
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic digit_strobe_i,
	input wire logic sector_track_reader_i,
	input wire logic ce_i,
	input wire logic convert_bit_i,
	// Outputs watched
	input wire logic busy_o,
	input wire logic [4:0] relay_select_counter_o,
	input wire logic relay_gate_guard_o,
	input wire logic sector_match_flag_o,
	input wire logic drum_write_enable_flag_o,
	input wire logic extended_word_driver_o,
	input wire logic sector_compare_driver_o,
	input wire logic [4:0] conversion_digit_counter_o,
	input wire logic converted_word_write_circuit_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);
	a_head_gated: assert property (ce_i && digit_strobe_i &&
		!drum_write_enable_flag_o |=> !converted_word_write_circuit_o)
		else $error("head not gated");
	a_head_bit: assert property (ce_i && digit_strobe_i &&
		drum_write_enable_flag_o
		|=> converted_word_write_circuit_o == $past(convert_bit_i))
		else $error("head bit wrong");
	a_ce_freeze: assert property (!ce_i |=>
		$stable(conversion_digit_counter_o) && $stable(busy_o) &&
		$stable(sector_match_flag_o) && $stable(drum_write_enable_flag_o)
		&& $stable(relay_gate_guard_o)) else $error("enable low moved");
	a_ext_word: assert property (extended_word_driver_o ==
		(sector_match_flag_o || drum_write_enable_flag_o))
		else $error("extended word wrong");
	a_match_six: assert property (ce_i && sector_match_flag_o &&
		drum_write_enable_flag_o && digit_strobe_i &&
		conversion_digit_counter_o == AICS_DIGIT_SIX |=> !sector_match_flag_o)
		else $error("match not cleared at digit six");
	a_write_join: assert property ($rose(drum_write_enable_flag_o)
		|-> sector_match_flag_o) else $error("write without match");
	a_match_cmp: assert property ($rose(sector_match_flag_o)
		|-> $past(sector_compare_driver_o && digit_strobe_i))
		else $error("match without compare");
	a_guard_late: assert property ($rose(busy_o)
		|-> !relay_gate_guard_o ##1 relay_gate_guard_o)
		else $error("guard timing wrong");
	a_relay_hold: assert property (busy_o && $past(busy_o)
		|-> $stable(relay_select_counter_o)) else $error("relay moved");
	a_digit_bin: assert property (ce_i && digit_strobe_i &&
		!sector_track_reader_i &&
		conversion_digit_counter_o != AICS_DIGIT_LAST
		|=> conversion_digit_counter_o == $past(conversion_digit_counter_o)
		+ 5'h01) else $error("digit count not binary");
	a_write_end: assert property ($fell(drum_write_enable_flag_o)
		|-> $past(digit_strobe_i && conversion_digit_counter_o ==
		AICS_DIGIT_LAST)) else $error("write cleared off word end");
endmodule
bind aics_sequencer aics_properties u_aics_properties (.clk_i, .srst_i,
	.digit_strobe_i, .sector_track_reader_i, .ce_i, .convert_bit_i,
	.busy_o, .relay_select_counter_o,
	.relay_gate_guard_o, .sector_match_flag_o, .drum_write_enable_flag_o,
	.extended_word_driver_o, .sector_compare_driver_o,
	.conversion_digit_counter_o, .converted_word_write_circuit_o);

// file: verification/analog_input_conversion_sequencer_test.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module analog_input_conversion_sequencer_test;
	import aics_pkg::*;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic start_i = 1'b0;
	logic rdy = 1'b0;
	logic ce = 1'b1;
	logic pw = 1'b0;
	logic hd;
	logic [17:0] hw = 18'h00000;
	logic [4:0] rset = 5'h00;
	logic [6:0] tsec = 7'h00;
	logic [17:0] pat = 18'h00000;
	logic [17:0] exp_q[$];
	logic busy, grd, mf, wf, vld, ds, rd, rm, cb;
	logic [4:0] rsc;
	logic [6:0] sc;
	logic [17:0] wdat;
	int failures = 0;
	int checks = 0;
	int seed = 17;
	int cycles = 0;
	int ms, ws, rv, n;
	aics_drum_model u_aics_drum_model (.clk_i, .srst_i, .pat_i(pat),
		.ds_o(ds), .rd_o(rd), .rm_o(rm), .cb_o(cb));
	aics_sequencer u_aics_sequencer (.clk_i, .srst_i, .ce_i(ce),
		.digit_strobe_i(ds), .sector_track_reader_i(rd),
		.revolution_mark_i(rm), .start_i, .relay_set_i(rset),
		.target_sector_i(tsec), .busy_o(busy), .convert_bit_i(cb),
		.relay_select_counter_o(rsc), .relay_gate_guard_o(grd),
		.sector_match_flag_o(mf), .drum_write_enable_flag_o(wf),
		.extended_word_driver_o(), .sector_compare_driver_o(),
		.conversion_digit_counter_o(), .sector_count_o(sc),
		.converted_word_write_circuit_o(hd), .word_valid_o(vld),
		.word_ready_i(rdy), .word_data_o(wdat));
	task automatic cmp_word(input string nm, input logic [17:0] e,
		input logic [17:0] g);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_bit(input string nm, input logic e, input logic g);
		cmp_word(nm, {17'h00000, e}, {17'h00000, g});
	endtask
	task automatic tally_and_finish;
		$display("Checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
		forever #4 clk_i = ~clk_i;
	// Three conversions take under five revolutions each
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 100000)
		begin
			failures++;
			tally_and_finish;
		end
	end
	initial
	begin
		repeat (3) @(negedge clk_i);
		srst_i = 1'b0;
		cmp_bit("idle busy", 1'b0, busy);
		cmp_bit("idle valid", 1'b0, vld);
		for (int k = 0; k < 3; k++)
		begin
			rset = (k == 0) ? 5'h1F : 5'($random(seed));
			tsec = (k == 1) ? 7'h7F : 7'($random(seed));
			pat = (k == 2) ? 18'h20001 : 18'($random(seed));
			start_i = 1'b1;
			@(negedge clk_i);
			cmp_bit("busy", 1'b1, busy);
			// Second start while busy must be ignored
			rset = ~rset;
			@(negedge clk_i);
			start_i = 1'b0;
			cmp_word("relay", {13'h0000, ~rset}, {13'h0000, rsc});
			cmp_bit("guard", 1'b1, grd);
			ms = 0;
			ws = 0;
			rv = 0;
			n = 0;
			pw = 1'b0;
			while (busy === 1'b1 && n < 30000)
			begin
				@(negedge clk_i);
				n++;
				// Head shows the bit taken at the previous strobe
				if (pw)
					hw = {hd, hw[17:1]};
				pw = ds === 1'b1 && wf === 1'b1;
				if (rm === 1'b1 && mf !== 1'b1)
					rv++;
				if (mf === 1'b1 && ms == 0 && ds !== 1'b1)
					cmp_word("sector", 18'(7'(tsec + 7'h01)), 18'(sc));
				if (ds === 1'b1 && mf === 1'b1)
					ms++;
				if (ds === 1'b1 && wf === 1'b1)
					ws++;
			end
			cmp_bit("done", 1'b0, busy);
			cmp_word("match span", 18'h00019, 18'(ms));
			cmp_word("write span", 18'h00012, 18'(ws));
			cmp_bit("settle", 1'b1, rv >= 3);
			cmp_bit("flags", 1'b0, mf | wf);
			cmp_word("head", pat, hw);
			exp_q.push_back(pat);
		end
		// Far side stalled through all three conversions
		// Enable low in a strobe gap: ready alone must not pop
		while (ds !== 1'b1)
			@(negedge clk_i);
		@(negedge clk_i);
		ce = 1'b0;
		rdy = 1'b1;
		@(negedge clk_i);
		ce = 1'b1;
		cmp_bit("frozen valid", 1'b1, vld);
		cmp_word("frozen data", exp_q[0], wdat);
		while (exp_q.size() > 0)
		begin
			cmp_bit("valid", 1'b1, vld);
			cmp_word("data", exp_q.pop_front(), wdat);
			@(negedge clk_i);
		end
		cmp_bit("empty", 1'b0, vld);
		tally_and_finish;
	end
endmodule
